// ===== common/rtc_pkg.sv
// Purpose: Shared constants for the backup-domain real-time clock block
// Assumes: One clock domain, register port with one-cycle read latency
// Notes:   Word-indexed register map, each register one 32-bit word
package rtc_pkg;
  localparam int          ADDR_W        = 6;
  localparam int          DATA_W        = 32;
  localparam int          BKP_WORDS     = 10;
  localparam int          BKP_W         = 16;
  localparam int          PRESC_W       = 20;
  localparam int          CAL_W         = 7;
  localparam int          CAL_WIN_W     = 20;
  localparam int          CAL_OUT_DIV_W = 6;

  localparam logic [5:0]  OFS_CONTROL   = 6'h00;
  localparam logic [5:0]  OFS_STATUS    = 6'h01;
  localparam logic [5:0]  OFS_RELOAD    = 6'h02;
  localparam logic [5:0]  OFS_DIVIDER   = 6'h03;
  localparam logic [5:0]  OFS_COUNT     = 6'h04;
  localparam logic [5:0]  OFS_ALARM     = 6'h05;
  localparam logic [5:0]  OFS_CALIB     = 6'h06;
  localparam logic [5:0]  OFS_BKP_CTRL  = 6'h07;
  localparam logic [5:0]  OFS_PWR_CTRL  = 6'h08;
  localparam logic [5:0]  OFS_PWR_STAT  = 6'h09;
  localparam logic [5:0]  OFS_BKP_BASE  = 6'h10;

  // Control register bits
  localparam int          CTL_SEC_IE    = 0;
  localparam int          CTL_OVF_IE    = 1;
  localparam int          CTL_ALR_IE    = 2;
  // Status bits (write one to clear)
  localparam int          ST_SEC        = 0;
  localparam int          ST_OVF        = 1;
  localparam int          ST_ALR        = 2;
  localparam int          ST_TAMPER     = 3;
  // Calibration register bits
  localparam int          CAL_CCO       = 7;
  localparam int          CAL_ALARM_SECOND_OUTPUT_ENABLE      = 8;
  localparam int          CAL_ALARM_SECOND_OUTPUT_SELECT      = 9;
  // Backup control bits
  localparam int          BK_TPE        = 0;
  localparam int          BK_TAMPER_ACTIVE_LEVEL       = 1;
  localparam int          BK_TAMPER_INTERRUPT_ENABLE       = 2;
  // Power control bits
  localparam int          PW_DEEP_SLEEP_REGULATOR_LOWPOWER       = 0;
  localparam int          PW_POWER_DOWN_SELECT       = 1;
  localparam int          PW_SLEEPD     = 2;
  localparam int          PW_RESUME_PIN_ENABLE       = 3;
  localparam int          PW_WUF        = 4;

  localparam logic [19:0] RELOAD_RESET  = 20'h0_7FFF;

  typedef enum logic [1:0] {
    PWR_RUN     = 2'b00,
    PWR_STOP    = 2'b01,
    PWR_STANDBY = 2'b11
  } pwr_state_type;
endpackage

// ===== hdl/rtc_backup_domain.sv
// Purpose: Backup-domain RTC: prescaler, counter, alarm, calibration, tamper, wake
// Assumes: i_clk is the RTC clock; i_rst_b is the backup-domain reset only
// Notes:   Backup reset only; system resets do not reach this block
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rtc_backup_domain
  import rtc_pkg::*;
#(
  parameter int PW = PRESC_W,
  parameter int NB = BKP_WORDS
) (
  // Clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_ce,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  // Tamper / calibration pin
  input  wire logic              i_tamper_pin,
  output logic                   o_tamper_pin,
  output logic                   o_tamper_pin_oe,
  // Wake sources and power control
  input  wire logic              i_wake_pin,
  input  wire logic              i_wfi,
  input  wire logic              i_line_wake,
  input  wire logic              i_voltage_wake,
  input  wire logic              i_usb_wake,
  output logic                   o_stop_mode,
  output logic                   o_standby_mode,
  output logic                   o_regulator_lowpower,
  output logic                   o_wake_clock_revert,
  output logic                   o_restart_request,
  // Events
  output logic                   o_irq_second,
  output logic                   o_irq_overflow,
  output logic                   o_irq_alarm,
  output logic                   o_irq_tamper
);
  logic [PW-1:0]        reload_reg, presc_reg;
  logic [DATA_W-1:0]    count_reg, alarm_reg;
  logic [2:0]           ctl_reg;
  logic [3:0]           status_reg;
  logic [9:0]           calib_reg;
  logic [2:0]           bkctl_reg;
  logic [4:0]           pwr_reg;
  logic [CAL_WIN_W-1:0] win_reg;
  logic [CAL_W-1:0]     blank_reg;
  logic [CAL_OUT_DIV_W-1:0] div64_reg;
  logic                 tamper_d_reg, wake_d_reg;
  logic                 rd_bkp_reg;
  logic [DATA_W-1:0]    rdata_next, rdata_reg;
  pwr_state_type        pstate_reg, pstate_next;
  logic                 restart_reg, revert_reg;
  logic                 cco_d_reg;
  logic [BKP_W-1:0]     rdata_bkp;
  localparam int        BKP_IDX_W = $clog2(NB);

  // Register decode
  wire logic sel_ctl = (i_addr == OFS_CONTROL);
  wire logic sel_st  = (i_addr == OFS_STATUS);
  wire logic sel_rl  = (i_addr == OFS_RELOAD);
  wire logic sel_cnt = (i_addr == OFS_COUNT);
  wire logic sel_alr = (i_addr == OFS_ALARM);
  wire logic sel_cal = (i_addr == OFS_CALIB);
  wire logic sel_bk  = (i_addr == OFS_BKP_CTRL);
  wire logic sel_pw  = (i_addr == OFS_PWR_CTRL);
  wire logic sel_ps  = (i_addr == OFS_PWR_STAT);
  wire logic sel_bkp = (i_addr >= OFS_BKP_BASE) &&
                       (i_addr < OFS_BKP_BASE + ADDR_W'(NB));
  wire logic [BKP_IDX_W-1:0] bkp_idx = BKP_IDX_W'(i_addr - OFS_BKP_BASE);

  // Calibration blanking: skip the first N cycles of each window
  wire logic win_wrap  = (win_reg == '1);
  wire logic blank_now = (blank_reg != '0);
  // Prescaler advances only on unblanked cycles, time base = clk/(reload+1)
  wire logic presc_tick = !blank_now && (presc_reg == '0);
  wire logic cnt_ovf    = presc_tick && (count_reg == '1);
  wire logic alarm_hit  = presc_tick && ((count_reg + 1'b1) == alarm_reg);

  // Tamper pin shared with calibration output
  wire logic cco_on     = calib_reg[CAL_CCO];
  // One quiet cycle after the divided clock leaves the pin, so its last level is no edge
  wire logic tamper_arm = bkctl_reg[BK_TPE] && !cco_on && !cco_d_reg;
  wire logic edge_rise  = i_tamper_pin && !tamper_d_reg;
  wire logic edge_fall  = !i_tamper_pin && tamper_d_reg;
  wire logic tamper_evt = tamper_arm &&
                          (bkctl_reg[BK_TAMPER_ACTIVE_LEVEL] ? edge_fall : edge_rise);
  wire logic wake_rise  = i_wake_pin && !wake_d_reg && pwr_reg[PW_RESUME_PIN_ENABLE];

  // Hardware set wins over software write-one-clear
  wire logic [3:0] st_set = {tamper_evt, alarm_hit, cnt_ovf, presc_tick};
  wire logic [3:0] st_clr = (i_wr && sel_st) ? i_wdata[3:0] : 4'h0;

  wire logic [PW-1:0] presc_next =
      (i_wr && sel_rl) ? i_wdata[PW-1:0] :
      blank_now        ? presc_reg :
      presc_tick       ? reload_reg : presc_reg - 1'b1;

  wire logic [DATA_W-1:0] count_next =
      (i_wr && sel_cnt) ? i_wdata :
      presc_tick        ? count_reg + 1'b1 : count_reg;

  // Power state sequencing
  always_comb begin
    pstate_next = pstate_reg;
    case (pstate_reg)
      PWR_RUN: begin
        if (i_wfi && pwr_reg[PW_SLEEPD]) begin
          pstate_next = pwr_reg[PW_POWER_DOWN_SELECT] ? PWR_STANDBY : PWR_STOP;
        end
      end
      PWR_STOP: begin
        if (i_line_wake || alarm_hit || i_voltage_wake || i_usb_wake) begin
          pstate_next = PWR_RUN;
        end
      end
      PWR_STANDBY: begin
        if (wake_rise || alarm_hit) begin
          pstate_next = PWR_RUN;
        end
      end
      default: pstate_next = PWR_RUN;
    endcase
  end

  // Read mux
  always_comb begin
    rdata_next = '0;
    if (sel_ctl) begin
      rdata_next[2:0] = ctl_reg;
    end else if (sel_st) begin
      rdata_next[3:0] = status_reg;
    end else if (sel_rl) begin
      rdata_next[PW-1:0] = reload_reg;
    end else if (i_addr == OFS_DIVIDER) begin
      rdata_next[PW-1:0] = presc_reg;
    end else if (sel_cnt) begin
      rdata_next = count_reg;
    end else if (sel_alr) begin
      rdata_next = alarm_reg;
    end else if (sel_cal) begin
      rdata_next[9:0] = calib_reg;
    end else if (sel_bk) begin
      rdata_next[2:0] = bkctl_reg;
    end else if (sel_pw || sel_ps) begin
      rdata_next[4:0] = pwr_reg;
    end
  end

  rtc_backup_mem #(
    .WORDS (NB),
    .W     (BKP_W)
  ) u_mem (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_ce    (i_ce),
    .i_wr    (i_wr && sel_bkp),
    .i_addr  (bkp_idx),
    .i_wdata (i_wdata[BKP_W-1:0]),
    .i_wipe  (tamper_evt),
    .o_rdata (rdata_bkp)
  );

  // Only the backup-domain reset clears this state; system resets are not wired here
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      reload_reg   <= PW'(RELOAD_RESET);
      presc_reg    <= PW'(RELOAD_RESET);
      count_reg    <= '0;
      alarm_reg    <= '1;
      ctl_reg      <= '0;
      status_reg   <= '0;
      calib_reg    <= '0;
      bkctl_reg    <= '0;
      win_reg      <= '0;
      blank_reg    <= '0;
      div64_reg    <= '0;
      tamper_d_reg <= 1'b0;
      cco_d_reg    <= 1'b0;
      wake_d_reg   <= 1'b0;
      rd_bkp_reg   <= 1'b0;
      rdata_reg    <= '0;
    end else if (i_ce) begin
      presc_reg    <= presc_next;
      count_reg    <= count_next;
      win_reg      <= win_reg + 1'b1;
      blank_reg    <= win_wrap ? calib_reg[CAL_W-1:0] :
                      blank_now ? blank_reg - 1'b1 : blank_reg;
      div64_reg    <= div64_reg + 1'b1;
      status_reg   <= (status_reg & ~st_clr) | st_set;
      tamper_d_reg <= i_tamper_pin;
      cco_d_reg    <= cco_on;
      wake_d_reg   <= i_wake_pin;
      rd_bkp_reg   <= i_rd && sel_bkp;
      rdata_reg    <= rdata_next;
      if (i_wr && sel_rl)  reload_reg <= i_wdata[PW-1:0];
      if (i_wr && sel_alr) alarm_reg  <= i_wdata;
      if (i_wr && sel_ctl) ctl_reg    <= i_wdata[2:0];
      if (i_wr && sel_cal) calib_reg  <= i_wdata[9:0];
      if (i_wr && sel_bk)  bkctl_reg  <= i_wdata[2:0];
    end
  end

  // Power controls; wake flag set by hardware wins over clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_reg     <= '0;
      pstate_reg  <= PWR_RUN;
      restart_reg <= 1'b0;
      revert_reg  <= 1'b0;
    end else if (i_ce) begin
      pstate_reg  <= pstate_next;
      restart_reg <= (pstate_reg == PWR_STANDBY) && (pstate_next == PWR_RUN);
      revert_reg  <= (pstate_reg == PWR_STOP) && (pstate_next == PWR_RUN);
      if (i_wr && sel_pw) pwr_reg[3:0] <= i_wdata[3:0];
      if (wake_rise || (pstate_reg != PWR_RUN && pstate_next == PWR_RUN)) begin
        pwr_reg[PW_WUF] <= 1'b1;
      end else if (i_wr && sel_ps && i_wdata[PW_WUF]) begin
        pwr_reg[PW_WUF] <= 1'b0;
      end
      if (pstate_next != PWR_RUN && pstate_reg != PWR_RUN) begin
        pwr_reg[PW_SLEEPD] <= 1'b0;
      end
    end
  end

  // Outputs
  assign o_rdata              = rd_bkp_reg ? {{(DATA_W-BKP_W){1'b0}}, rdata_bkp} : rdata_reg;
  assign o_tamper_pin         = div64_reg[CAL_OUT_DIV_W-1];
  assign o_tamper_pin_oe      = cco_on;
  assign o_stop_mode          = (pstate_reg == PWR_STOP);
  assign o_standby_mode       = (pstate_reg == PWR_STANDBY);
  assign o_regulator_lowpower = o_stop_mode && pwr_reg[PW_DEEP_SLEEP_REGULATOR_LOWPOWER];
  assign o_wake_clock_revert  = revert_reg;
  assign o_restart_request    = restart_reg;
  assign o_irq_second         = status_reg[ST_SEC] && ctl_reg[CTL_SEC_IE];
  assign o_irq_overflow       = status_reg[ST_OVF] && ctl_reg[CTL_OVF_IE];
  assign o_irq_alarm          = status_reg[ST_ALR] && ctl_reg[CTL_ALR_IE];
  assign o_irq_tamper         = status_reg[ST_TAMPER] && bkctl_reg[BK_TAMPER_INTERRUPT_ENABLE];
endmodule
`default_nettype wire

// ===== hdl/rtc_backup_mem.sv
// Purpose: Backup data word store with registered read and bulk wipe
// Assumes: Wipe has priority over a write in the same cycle
// Notes:   Read data come from a register
`timescale 1ns/1ps
`default_nettype none
module rtc_backup_mem #(
  parameter int WORDS = 10,
  parameter int W     = 16
) (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_ce,
  // Access
  input  wire logic                     i_wr,
  input  wire logic [$clog2(WORDS)-1:0] i_addr,
  input  wire logic [W-1:0]             i_wdata,
  input  wire logic                     i_wipe,
  output logic      [W-1:0]             o_rdata
);
  logic [W-1:0] mem_reg [WORDS];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < WORDS; k++) mem_reg[k] <= '0;
      o_rdata <= '0;
    end else if (i_ce) begin
      if (i_wipe) begin
        for (int k = 0; k < WORDS; k++) mem_reg[k] <= '0;
      end else if (i_wr) begin
        mem_reg[i_addr] <= i_wdata;
      end
      o_rdata <= i_wipe ? '0 : mem_reg[i_addr];
    end
  end
endmodule
`default_nettype wire

// ===== sim/rtc_backup_domain_properties.sv
// Purpose: Port-level temporal checks for the backup-domain RTC
// Assumes: Single clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of rtc_backup_domain
`timescale 1ns/1ps
`default_nettype none
module rtc_backup_domain_properties
  import rtc_pkg::*;
(
  // Clock, reset and register port
  input wire logic              i_clk,
  input wire logic              i_rst_b,
  input wire logic              i_ce,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  // Pin outputs, wake inputs, power and event outputs
  input wire logic              o_tamper_pin,
  input wire logic              o_tamper_pin_oe,
  input wire logic              i_line_wake,
  input wire logic              i_voltage_wake,
  input wire logic              i_usb_wake,
  input wire logic              o_stop_mode,
  input wire logic              o_standby_mode,
  input wire logic              o_regulator_lowpower,
  input wire logic              o_wake_clock_revert,
  input wire logic              o_restart_request,
  input wire logic              o_irq_tamper
);
  wire cco_bit = i_wdata[CAL_CCO];
  wire any_wake = i_line_wake | i_voltage_wake | i_usb_wake;
  wire cal_wr = i_ce & i_wr & (i_addr == OFS_CALIB);

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_oe_follows_cco: assert property (cal_wr |=> o_tamper_pin_oe == $past(cco_bit))
    else $error("pin enable does not follow calibration output bit");
  a_div_steady: assert property (o_tamper_pin_oe && $past(o_tamper_pin_oe)
    && $changed(o_tamper_pin) |=> $stable(o_tamper_pin)[*8])
    else $error("divided clock toggles too soon");
  a_no_tamper_cal: assert property (o_tamper_pin_oe && $past(o_tamper_pin_oe)
    |-> !$rose(o_irq_tamper))
    else $error("tamper event while pin carries divided clock");
  a_lp_in_stop: assert property (o_regulator_lowpower |-> o_stop_mode)
    else $error("regulator low power outside stop");
  a_modes_apart: assert property (!(o_stop_mode && o_standby_mode))
    else $error("stop and standby together");
  a_stop_wakes: assert property (i_ce && o_stop_mode && any_wake
    |-> ##[1:2] !o_stop_mode)
    else $error("wake source did not end stop");
  a_stop_revert: assert property ($fell(o_stop_mode) |-> ##[0:1] o_wake_clock_revert)
    else $error("no clock revert after stop");
  a_revert_pulse: assert property (o_wake_clock_revert |=> !o_wake_clock_revert)
    else $error("clock revert longer than one cycle");
  a_standby_restart: assert property ($fell(o_standby_mode) |-> ##[0:1] o_restart_request)
    else $error("no restart after standby");
  a_unmapped_zero: assert property (i_ce && i_rd && i_addr == 6'h0A |=> o_rdata == '0)
    else $error("unmapped read not zero");

  c_cal_out: cover property ($rose(o_tamper_pin_oe));
  c_stop_exit: cover property ($fell(o_stop_mode));
  c_standby_exit: cover property ($fell(o_standby_mode));
endmodule
bind rtc_backup_domain rtc_backup_domain_properties props (.i_clk, .i_rst_b, .i_ce, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .o_tamper_pin, .o_tamper_pin_oe, .i_line_wake,
  .i_voltage_wake, .i_usb_wake, .o_stop_mode, .o_standby_mode, .o_regulator_lowpower,
  .o_wake_clock_revert, .o_restart_request, .o_irq_tamper);
`default_nettype wire

// ===== sim/test_rtc_calibration_tamper_lowpower.sv
// Purpose: Self-checking bench for the backup-domain RTC
// Assumes: Register reads answer one cycle after the strobe
// Notes:   Reads queue their expectation; a monitor compares the answers
`timescale 1ns/1ps
`default_nettype none
module test_rtc_calibration_tamper_lowpower;
  import rtc_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_type;
  logic i_clk = 0, i_rst_b = 0, i_ce = 1, i_wr = 0, i_rd = 0, i_wfi = 0;
  logic i_wake_pin = 0, i_line_wake = 0, i_voltage_wake = 0, i_usb_wake = 0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0, o_rdata, x;
  logic o_tamper_pin, o_tamper_pin_oe, o_stop_mode, o_standby_mode, o_regulator_lowpower;
  logic o_wake_clock_revert, o_restart_request, o_irq_second, o_irq_overflow;
  logic o_irq_alarm, o_irq_tamper, rd_seen = 0, pin_drv = 0, p;
  logic [15:0] bk[BKP_WORDS];
  note_type q[$], nt;
  int i, n, t0, cyc = 0, checks = 0, fail_count = 0;
  int rl[3] = '{4, 49, 59};
  // The shared pad carries our own divided clock while the output is enabled
  wire i_tamper_pin = o_tamper_pin_oe ? o_tamper_pin : pin_drv;
  wire [4:0] mon = {o_tamper_pin_oe, o_irq_tamper, o_regulator_lowpower,
                    o_standby_mode, o_stop_mode};

  rtc_backup_domain uut (.i_clk, .i_rst_b, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_tamper_pin, .o_tamper_pin, .o_tamper_pin_oe, .i_wake_pin, .i_wfi, .i_line_wake,
    .i_voltage_wake, .i_usb_wake, .o_stop_mode, .o_standby_mode, .o_regulator_lowpower,
    .o_wake_clock_revert, .o_restart_request, .o_irq_second, .o_irq_overflow, .o_irq_alarm,
    .o_irq_tamper);

  initial begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc <= cyc + 1;
  always @(posedge i_clk) begin
    if (rd_seen) begin
      nt = q.pop_front();
      chk(o_rdata & nt.m, nt.e);
    end
    rd_seen <= i_rd & i_ce & i_rst_b;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
    @(posedge i_clk);
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    q.push_back('{e, m});
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    @(posedge i_clk);
  endtask
  // Strobe lands exactly n cycles after the write that returned at t0
  task rd_after(input int n, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    while (cyc != t0 + n - 1) @(posedge i_clk);
    rd(a, e);
  endtask
  task wfi();
    i_wfi <= 1;
    @(posedge i_clk);
    i_wfi <= 0;
    @(posedge i_clk);
  endtask
  task await(input int b, input logic v, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(negedge i_clk);
      if (mon[b] === v) break;
    end
    chk(mon[b], v);
    @(posedge i_clk);
  endtask
  task wrap_up;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    wrap_up;
  end

  initial begin
    void'($urandom(9));
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1;
    rd(OFS_RELOAD, 32'h0000_7FFF);
    rd(OFS_ALARM, 32'hFFFF_FFFF);
    rd(OFS_COUNT, 32'h0000_0000);
    wr(6'h0A, 32'hFFFF_FFFF);
    rd(6'h0A, 32'h0000_0000);
    rd(OFS_CALIB, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0001);
    wr(OFS_RELOAD, 32'h0000_0004);
    // Writing the reload restarts the prescaler from the new value
    repeat (32800) @(posedge i_clk);
    for (i = 0; i < 3; i++) begin
      wr(OFS_RELOAD, 32'(rl[i]));
      repeat (64) @(posedge i_clk);
      x = $urandom & 32'h00FF_FFFF;
      wr(OFS_COUNT, x);
      t0 = cyc;
      rd_after(10 * (rl[i] + 1), OFS_COUNT, x + 10);
    end
    chk(o_irq_second, 1'b1);
    x = $urandom & 32'h00FF_FFFF;
    wr(OFS_COUNT, x);
    t0 = cyc;
    wr(OFS_PWR_CTRL, 32'h0000_0004);
    wfi();
    await(0, 1'b1, 16);
    rd_after(600, OFS_COUNT, x + 10);
    for (i = 0; i < 3; i++) begin
      {i_usb_wake, i_voltage_wake, i_line_wake} <= 3'(1 << i);
      await(0, 1'b0, 16);
      {i_usb_wake, i_voltage_wake, i_line_wake} <= 3'h0;
      wr(OFS_PWR_CTRL, 32'h0000_0005);
      wfi();
      await(2, 1'b1, 16);
    end
    i_line_wake <= 1;
    await(0, 1'b0, 16);
    i_line_wake <= 0;
    wr(OFS_PWR_STAT, 32'h0000_0010);
    wr(OFS_PWR_CTRL, 32'h0000_0008);
    wr(OFS_PWR_CTRL, 32'h0000_000A);
    wr(OFS_PWR_CTRL, 32'h0000_000E);
    wfi();
    await(1, 1'b1, 16);
    i_wake_pin <= 1;
    await(1, 1'b0, 16);
    rd(OFS_PWR_STAT, 32'h0000_001A, 32'h0000_001F);
    i_wake_pin <= 0;
    wr(OFS_CONTROL, 32'h0000_0004);
    x = $urandom & 32'h00FF_FFFF;
    wr(OFS_COUNT, x);
    wr(OFS_ALARM, x + 2);
    wr(OFS_PWR_STAT, 32'h0000_0010);
    wr(OFS_PWR_CTRL, 32'h0000_000E);
    wfi();
    await(1, 1'b1, 16);
    await(1, 1'b0, 200);
    chk(o_irq_alarm, 1'b1);
    // Counter wraps on the next tick, well inside 70 cycles at reload 59
    wr(OFS_CONTROL, 32'h0000_0002);
    wr(OFS_COUNT, 32'hFFFF_FFFF);
    repeat (70) @(posedge i_clk);
    chk(o_irq_overflow, 1'b1);
    rd(OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
    wr(OFS_BKP_CTRL, 32'h0000_0000);
    wr(OFS_BKP_CTRL, 32'h0000_0004);
    wr(OFS_BKP_CTRL, 32'h0000_0005);
    for (i = 0; i < BKP_WORDS; i++) begin
      bk[i] = 16'($urandom);
      wr(OFS_BKP_BASE + 6'(i), {16'h0000, bk[i]});
    end
    wr(OFS_CALIB, 32'h0000_0080);
    await(4, 1'b1, 16);
    p = o_tamper_pin;
    for (n = 0; n < 80 && o_tamper_pin === p; n++) @(negedge i_clk);
    p = o_tamper_pin;
    for (n = 0; n < 80 && o_tamper_pin === p; n++) @(negedge i_clk);
    chk(n, 32);
    @(posedge i_clk);
    repeat (70) @(posedge i_clk);
    rd(OFS_BKP_BASE, {16'h0000, bk[0]});
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0008);
    wr(OFS_CALIB, 32'h0000_007F);
    rd(OFS_CALIB, 32'h0000_007F);
    await(4, 1'b0, 16);
    pin_drv <= 1;
    await(3, 1'b1, 16);
    rd(OFS_BKP_BASE, 32'h0000_0000);
    rd(OFS_BKP_BASE + 6'h09, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_0008);
    pin_drv <= 0;
    repeat (6) @(posedge i_clk);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0008);
    wr(OFS_BKP_CTRL, 32'h0000_0002);
    wr(OFS_BKP_CTRL, 32'h0000_0006);
    wr(OFS_BKP_CTRL, 32'h0000_0007);
    wr(OFS_BKP_BASE, {16'h0000, bk[0]});
    pin_drv <= 1;
    repeat (6) @(posedge i_clk);
    rd(OFS_BKP_BASE, {16'h0000, bk[0]});
    pin_drv <= 0;
    await(3, 1'b1, 16);
    rd(OFS_BKP_BASE, 32'h0000_0000);
    // Clock enable low must freeze the prescaler one step after the reload
    wr(OFS_RELOAD, 32'h0000_7FFE);
    i_ce <= 0;
    repeat (200) @(posedge i_clk);
    i_ce <= 1;
    rd(OFS_DIVIDER, 32'h0000_7FFD);
    rd(OFS_RELOAD, 32'h0000_7FFE);
    // Let the monitor take the last answer before the verdict
    repeat (2) @(posedge i_clk);
    wrap_up;
  end
endmodule
`default_nettype wire
